//--- rtl/fifo_port_pkg.sv
// Shared constants and types for the parallel FIFO port.
package fifo_port_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 25_000_000; // Core clock rate
	localparam int unsigned WAKE_HOLD_MS  = 20;         // Least low time of wake strobe
	// Least time in whole cycles, never below one
	localparam int unsigned WAKE_HOLD_CYC =
		(WAKE_HOLD_MS * (CLK_HZ / 1000) + 0) < 1 ? 1 : WAKE_HOLD_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W       = 8;     // Byte lane width
	localparam int unsigned RX_DEPTH_DEF = 16;    // Receive FIFO depth default
	localparam int unsigned TX_DEPTH_DEF = 16;    // Transmit FIFO depth default
	localparam int unsigned WAKE_CNT_W   = 20;    // Width of the wake hold counter
	localparam logic [7:0]  BYTE_RST     = 8'h00; // Reset value of held read byte

	// ----------------------------------------------------------------
	// Configurable pin function codes
	// ----------------------------------------------------------------
	localparam logic [3:0] IO_SEL_INPUT    = 4'h0; // Released, pull only
	localparam logic [3:0] IO_SEL_TX_SPACE = 4'h1; // Mirror of transmit-space flag
	localparam logic [3:0] IO_SEL_RX_AVAIL = 4'h2; // Mirror of receive-available flag
	localparam logic [3:0] IO_SEL_SUSPEND  = 4'h3; // High during USB suspend
	localparam logic [3:0] IO_SEL_LOW      = 4'h4; // Constant low
	localparam logic [3:0] IO_SEL_HIGH     = 4'h5; // Constant high

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       remote_wake;      // Receive pin turns input in suspend
		logic       suspend_pull_low; // Input pins pull low in suspend
		logic [3:0] io5_sel;          // Function of config_io_5
		logic [3:0] io6_sel;          // Function of config_io_6
	} cfg_t;

	typedef struct packed {
		logic oe; // Pin driven
		logic o;  // Driven level
	} pin_drive_t;

	typedef struct packed {
		logic       valid; // Byte present
		logic [7:0] data;  // Byte value
	} byte_slot_t;

endpackage

//--- rtl/pin_sync.sv
// Two flip-flop synchroniser for pins entering the core clock domain.
`timescale 1ns/1ns
module pin_sync
	import fifo_port_pkg::*;
#(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync
);
	logic [W-1:0] meta_q; // First stage, read only by second stage
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q; // Second stage, safe to use
	logic [W-1:0] sync_d;

	// Next values
	always_comb begin
		meta_d = rst ? RST_VAL : pin;
		sync_d = rst ? RST_VAL : meta_q;
	end

	// Registers only
	always_ff @(posedge clk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync = sync_q;
endmodule

//--- rtl/skid_buf2.sv
// Two-entry buffer with valid/ready on both sides, outputs from flops.
`timescale 1ns/1ns
module skid_buf2
	import fifo_port_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);
	logic         head_v_q, head_v_d; // Entry shown to the drain
	logic [W-1:0] head_q,   head_d;
	logic         tail_v_q, tail_v_d; // Overflow entry during a stall
	logic [W-1:0] tail_q,   tail_d;
	logic         push;
	logic         pop;

	// Next values: tail refills head so a stall loses no word
	always_comb begin
		push     = in_valid & ~tail_v_q;
		pop      = head_v_q & out_ready;
		head_v_d = head_v_q;
		head_d   = head_q;
		tail_v_d = tail_v_q;
		tail_d   = tail_q;
		if (pop) begin
			if (tail_v_q) begin
				head_d = tail_q;
				if (push) begin
					tail_d = in_data;
				end else begin
					tail_v_d = 1'b0;
				end
			end else if (push) begin
				head_d = in_data;
			end else begin
				head_v_d = 1'b0;
			end
		end else if (push) begin
			if (!head_v_q) begin
				head_v_d = 1'b1;
				head_d   = in_data;
			end else begin
				tail_v_d = 1'b1;
				tail_d   = in_data;
			end
		end
		if (rst) begin
			head_v_d = 1'b0;
			tail_v_d = 1'b0;
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		head_v_q <= head_v_d;
		head_q   <= head_d;
		tail_v_q <= tail_v_d;
		tail_q   <= tail_d;
	end

	assign in_ready  = ~tail_v_q; // Full only when both entries hold
	assign out_valid = head_v_q;
	assign out_data  = head_q;
endmodule

//--- rtl/usb_parallel_fifo_port.sv
// Asynchronous 8-bit parallel FIFO port with suspend and wake handling.
//
// Overview of operation
// - Read strobe low drives receive byte
// - Read strobe falling advances to next byte
// - Write strobe falling captures bus byte
// - Receive flag low only when data waits
// - Status pins released while in reset
// - Remote wake: receive pin input in suspend
// - Receive pin low 20ms requests resume
// - Send-immediate low flushes transmit data
// - Send-immediate in suspend requests wakeup
// - Reset pin low resets the device
// - Inputs pulled up, optionally down suspended
// - Config memory selects configurable pin functions
`timescale 1ns/1ns
module usb_parallel_fifo_port
	import fifo_port_pkg::*;
#(
	parameter int unsigned RX_DEPTH  = RX_DEPTH_DEF,
	parameter int unsigned TX_DEPTH  = TX_DEPTH_DEF,
	parameter int unsigned WAKE_CYC  = WAKE_HOLD_CYC
) (
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	// Pins
	input  wire logic        RESET_N,
	input  wire logic        RD_N,
	input  wire logic        WR,
	input  wire logic [7:0]  DATA_I,
	output logic      [7:0]  DATA_O,
	output logic             DATA_OE,
	output logic             TX_SPACE_N_O,
	output logic             TX_SPACE_N_OE,
	input  wire logic        RX_AVAIL_N_I,
	output logic             RX_AVAIL_N_O,
	output logic             RX_AVAIL_N_OE,
	input  wire logic        SEND_NOW_WAKE_N,
	output logic             POWER_ENABLE_N,
	output logic             CONFIG_IO_5_O,
	output logic             CONFIG_IO_5_OE,
	output logic             CONFIG_IO_6_O,
	output logic             CONFIG_IO_6_OE,
	output logic             PULL_UP_EN,
	output logic             PULL_DOWN_EN,
	// Configuration memory and USB core side
	input  wire cfg_t        CFG,
	input  wire logic        USB_SUSPEND,
	input  wire logic        RXS_VALID,
	input  wire logic [7:0]  RXS_DATA,
	output logic             RXS_READY,
	output logic             TXS_VALID,
	output logic      [7:0]  TXS_DATA,
	input  wire logic        TXS_READY,
	output logic             TXS_FLUSH,
	output logic             RESUME_REQ
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam int RA_W = $clog2(RX_DEPTH); // Receive pointer width
	localparam int TA_W = $clog2(TX_DEPTH); // Transmit pointer width

	if (RX_DEPTH < 2 || (1 << RA_W) != RX_DEPTH) begin : g_bad_rx
		$error("RX_DEPTH must be a power of two, at least 2");
	end
	if (TX_DEPTH < 2 || (1 << TA_W) != TX_DEPTH) begin : g_bad_tx
		$error("TX_DEPTH must be a power of two, at least 2");
	end
	if (WAKE_CYC < 1 || WAKE_CYC >= (1 << WAKE_CNT_W)) begin : g_bad_wake
		$error("WAKE_CYC does not fit the wake counter");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Occupancy after one cycle of push and pop
	function automatic logic [15:0] occ_next(input logic [15:0] occ,
		input logic push, input logic pop);
		occ_next = occ + {15'h0000, push} - {15'h0000, pop};
	endfunction

	// Output drive of a configurable pin for a function code
	function automatic pin_drive_t io_drive(input logic [3:0] sel,
		input logic tx_n, input logic rx_n, input logic susp);
		case (sel)
			IO_SEL_TX_SPACE: io_drive = '{oe: 1'b1, o: tx_n};
			IO_SEL_RX_AVAIL: io_drive = '{oe: 1'b1, o: rx_n};
			IO_SEL_SUSPEND:  io_drive = '{oe: 1'b1, o: susp};
			IO_SEL_LOW:      io_drive = '{oe: 1'b1, o: 1'b0};
			IO_SEL_HIGH:     io_drive = '{oe: 1'b1, o: 1'b1};
			default:         io_drive = '{oe: 1'b0, o: 1'b0}; // Input, released
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [12:0] pins_s;      // Synchronised pins
	logic        rst_pin_n_s; // Reset pin, synchronised
	logic        rd_n_s;      // Read strobe
	logic        wr_s;        // Write strobe
	logic [7:0]  data_s;      // Data bus, aligned with the strobes
	logic        send_n_s;    // Send-immediate / wake
	logic        rx_pin_n_s;  // Receive pin as wake input

	pin_sync #(
		.W       (13),
		.RST_VAL (13'h1E00)
	) u_sync (
		.clk  (REF_CLK),
		.rst  (SRST),
		.pin  ({RESET_N, RD_N, SEND_NOW_WAKE_N, RX_AVAIL_N_I, WR, DATA_I}),
		.sync (pins_s)
	);

	assign {rst_pin_n_s, rd_n_s, send_n_s, rx_pin_n_s, wr_s, data_s} = pins_s;

	// Pin reset joins the core reset; it lags the pin by the sync depth
	logic rst;
	assign rst = SRST | ~rst_pin_n_s;

	// ----------------------------------------------------------------
	// Strobe edge detection
	// ----------------------------------------------------------------
	logic rd_prev_q, rd_prev_d;     // Read strobe one cycle ago
	logic wr_prev_q, wr_prev_d;     // Write strobe one cycle ago
	logic send_prev_q, send_prev_d; // Send strobe one cycle ago
	logic rd_fall;
	logic wr_fall;
	logic send_fall;

	// Falling edges of the synchronised strobes
	always_comb begin
		rd_fall     = rd_prev_q & ~rd_n_s;
		wr_fall     = wr_prev_q & ~wr_s;
		send_fall   = send_prev_q & ~send_n_s;
		rd_prev_d   = rst ? 1'b1 : rd_n_s;
		wr_prev_d   = rst ? 1'b0 : wr_s;
		send_prev_d = rst ? 1'b1 : send_n_s;
	end

	// Registers only
	always_ff @(posedge REF_CLK) begin
		rd_prev_q   <= rd_prev_d;
		wr_prev_q   <= wr_prev_d;
		send_prev_q <= send_prev_d;
	end

	// ----------------------------------------------------------------
	// Receive FIFO (USB core to controller)
	// ----------------------------------------------------------------
	logic [7:0]      rx_mem [RX_DEPTH]; // Receive storage
	logic [RA_W-1:0] rx_wp_q, rx_wp_d;  // Write pointer
	logic [RA_W-1:0] rx_rp_q, rx_rp_d;  // Read pointer
	logic [15:0]     rx_occ_q, rx_occ_d;
	logic            rx_push;
	logic            rx_pop;
	logic            rx_ready_q, rx_ready_d;
	logic [7:0]      rd_byte_q, rd_byte_d; // Byte held on the bus

	// Next values of the receive side
	always_comb begin
		rx_push   = RXS_VALID & rx_ready_q;
		rx_pop    = rd_fall & (rx_occ_q != 16'h0000);
		rx_wp_d   = rx_push ? RA_W'(rx_wp_q + 1'b1) : rx_wp_q;
		rx_rp_d   = rx_pop ? RA_W'(rx_rp_q + 1'b1) : rx_rp_q;
		rx_occ_d  = occ_next(rx_occ_q, rx_push, rx_pop);
		rd_byte_d = rx_pop ? rx_mem[rx_rp_q] : rd_byte_q;
		// Ready registered from next occupancy so it never overfills
		rx_ready_d = rx_occ_d < 16'(RX_DEPTH);
		if (rst) begin
			rx_wp_d    = '0;
			rx_rp_d    = '0;
			rx_occ_d   = 16'h0000;
			rd_byte_d  = BYTE_RST;
			rx_ready_d = 1'b0;
		end
	end

	// Registers only; storage has no reset
	always_ff @(posedge REF_CLK) begin
		if (rx_push) begin
			rx_mem[rx_wp_q] <= RXS_DATA;
		end
		rx_wp_q    <= rx_wp_d;
		rx_rp_q    <= rx_rp_d;
		rx_occ_q   <= rx_occ_d;
		rx_ready_q <= rx_ready_d;
		rd_byte_q  <= rd_byte_d;
	end

	assign RXS_READY = rx_ready_q;

	// ----------------------------------------------------------------
	// Transmit FIFO (controller to USB core)
	// ----------------------------------------------------------------
	logic [7:0]      tx_mem [TX_DEPTH]; // Transmit storage
	logic [TA_W-1:0] tx_wp_q, tx_wp_d;
	logic [TA_W-1:0] tx_rp_q, tx_rp_d;
	logic [15:0]     tx_occ_q, tx_occ_d;
	logic            tx_push;
	logic            tx_pop;
	logic            sk_ready;          // Drain buffer accepts
	logic            tx_full;

	// Next values; a write while full is dropped, the controller must wait
	always_comb begin
		tx_full  = tx_occ_q == 16'(TX_DEPTH);
		tx_push  = wr_fall & ~tx_full;
		tx_pop   = sk_ready & (tx_occ_q != 16'h0000);
		tx_wp_d  = tx_push ? TA_W'(tx_wp_q + 1'b1) : tx_wp_q;
		tx_rp_d  = tx_pop ? TA_W'(tx_rp_q + 1'b1) : tx_rp_q;
		tx_occ_d = occ_next(tx_occ_q, tx_push, tx_pop);
		if (rst) begin
			tx_wp_d  = '0;
			tx_rp_d  = '0;
			tx_occ_d = 16'h0000;
		end
	end

	// Registers only
	always_ff @(posedge REF_CLK) begin
		if (tx_push) begin
			tx_mem[tx_wp_q] <= data_s;
		end
		tx_wp_q  <= tx_wp_d;
		tx_rp_q  <= tx_rp_d;
		tx_occ_q <= tx_occ_d;
	end

	// Two-entry buffer toward the USB core; its stall backs up the FIFO
	skid_buf2 #(
		.W (DATA_W)
	) u_tx_buf (
		.clk       (REF_CLK),
		.rst       (rst),
		.in_valid  (tx_occ_q != 16'h0000),
		.in_data   (tx_mem[tx_rp_q]),
		.in_ready  (sk_ready),
		.out_valid (TXS_VALID),
		.out_data  (TXS_DATA),
		.out_ready (TXS_READY)
	);

	// ----------------------------------------------------------------
	// Remote wake detector
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		WK_IDLE  = 3'b001, // Pin high or wake not armed
		WK_COUNT = 3'b010, // Pin low, timing the hold
		WK_DONE  = 3'b100  // Resume asked, wait for pin release
	} wake_st_t;

	wake_st_t              wk_q, wk_d;
	logic [WAKE_CNT_W-1:0] wk_cnt_q, wk_cnt_d;
	logic                  wake_armed;
	logic                  wake_hit;

	// Counts the low time of the receive pin while it is an input
	always_comb begin
		wake_armed = CFG.remote_wake & USB_SUSPEND;
		wk_d       = wk_q;
		wk_cnt_d   = wk_cnt_q;
		wake_hit   = 1'b0;
		case (wk_q)
			WK_IDLE: begin
				wk_cnt_d = '0;
				if (wake_armed && !rx_pin_n_s) begin
					wk_d     = WK_COUNT;
					wk_cnt_d = WAKE_CNT_W'(1);
				end
			end
			WK_COUNT: begin
				if (!wake_armed || rx_pin_n_s) begin
					wk_d = WK_IDLE; // Short strobe, ignored
				end else if (wk_cnt_q >= WAKE_CNT_W'(WAKE_CYC)) begin
					wk_d     = WK_DONE;
					wake_hit = 1'b1;
				end else begin
					wk_cnt_d = WAKE_CNT_W'(wk_cnt_q + 1'b1);
				end
			end
			WK_DONE: begin
				if (!wake_armed || rx_pin_n_s) begin
					wk_d = WK_IDLE;
				end
			end
			default: wk_d = WK_IDLE;
		endcase
		if (rst) begin
			wk_d     = WK_IDLE;
			wk_cnt_d = '0;
		end
	end

	// Registers only
	always_ff @(posedge REF_CLK) begin
		wk_q     <= wk_d;
		wk_cnt_q <= wk_cnt_d;
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	logic       data_oe_d;
	logic [7:0] data_o_d;
	logic       tx_n_d, tx_oe_d;
	logic       rx_n_d, rx_oe_d;
	logic       pwr_n_d, pu_d, pd_d;
	logic       flush_d, resume_d;
	pin_drive_t io5_d, io6_d;

	// Every pin level is registered so the pins see no glitches
	always_comb begin
		data_oe_d = ~rd_n_s;
		data_o_d  = rd_byte_d;
		tx_n_d    = tx_occ_d == 16'(TX_DEPTH);
		tx_oe_d   = 1'b1;
		rx_n_d    = rx_occ_d == 16'h0000;
		rx_oe_d   = ~(CFG.remote_wake & USB_SUSPEND);
		pwr_n_d   = USB_SUSPEND;
		pd_d      = USB_SUSPEND & CFG.suspend_pull_low;
		pu_d      = ~pd_d;
		flush_d   = send_fall & ~USB_SUSPEND;
		resume_d  = (send_fall & USB_SUSPEND) | wake_hit;
		io5_d     = io_drive(CFG.io5_sel, tx_n_d, rx_n_d, USB_SUSPEND);
		io6_d     = io_drive(CFG.io6_sel, tx_n_d, rx_n_d, USB_SUSPEND);
		if (rst) begin
			data_oe_d = 1'b0;
			tx_oe_d   = 1'b0;
			rx_oe_d   = 1'b0;
			flush_d   = 1'b0;
			resume_d  = 1'b0;
			io5_d     = '{oe: 1'b0, o: 1'b0};
			io6_d     = '{oe: 1'b0, o: 1'b0};
		end
	end

	// Registers only
	always_ff @(posedge REF_CLK) begin
		DATA_OE        <= data_oe_d;
		DATA_O         <= data_o_d;
		TX_SPACE_N_O   <= tx_n_d;
		TX_SPACE_N_OE  <= tx_oe_d;
		RX_AVAIL_N_O   <= rx_n_d;
		RX_AVAIL_N_OE  <= rx_oe_d;
		POWER_ENABLE_N <= pwr_n_d;
		PULL_UP_EN     <= pu_d;
		PULL_DOWN_EN   <= pd_d;
		TXS_FLUSH      <= flush_d;
		RESUME_REQ     <= resume_d;
		CONFIG_IO_5_O  <= io5_d.o;
		CONFIG_IO_5_OE <= io5_d.oe;
		CONFIG_IO_6_O  <= io6_d.o;
		CONFIG_IO_6_OE <= io6_d.oe;
	end

endmodule

//--- verification/usb_parallel_fifo_port_checker.sv
// Port-level assertions for the parallel FIFO port.
`timescale 1ns/1ns
module usb_parallel_fifo_port_checker
	import fifo_port_pkg::*;
#(
	parameter int unsigned WAKE_CYC = WAKE_HOLD_CYC
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic RESET_N,
	input wire logic RD_N,
	input wire logic DATA_OE,
	input wire logic TX_SPACE_N_OE,
	input wire logic RX_AVAIL_N_I,
	input wire logic RX_AVAIL_N_O,
	input wire logic RX_AVAIL_N_OE,
	input wire logic SEND_NOW_WAKE_N,
	input wire logic USB_SUSPEND,
	input wire logic RXS_VALID,
	input wire logic RXS_READY,
	input wire logic TXS_FLUSH,
	input wire logic RESUME_REQ
);
	// ------------------------------------------------
	// Wake run tracking
	// ------------------------------------------------
	logic [WAKE_CNT_W-1:0] low_q;  // Cycles released pin seen low
	logic [WAKE_CNT_W-1:0] low_d;
	logic                  seen_q; // Resume seen in this run
	logic                  seen_d;

	// Run restarts whenever the pin goes high
	always_comb begin
		low_d = '0;
		if (!RX_AVAIL_N_OE && !RX_AVAIL_N_I) begin
			low_d = low_q + 1'b1;
		end
		seen_d = (low_d != '0) && (seen_q || RESUME_REQ);
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			low_q  <= '0;
			seen_q <= 1'b0;
		end else begin
			low_q  <= low_d;
			seen_q <= seen_d;
		end
	end

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	property p_oe_rst;
		$past(SRST) |-> !TX_SPACE_N_OE && !RX_AVAIL_N_OE && !DATA_OE;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("status pins driven in reset");

	property p_bus_rel;
		RD_N [*5] |-> !DATA_OE;
	endproperty
	a_bus_rel: assert property (p_bus_rel) else $error("bus driven, strobe high");

	property p_rd_drive;
		(!RD_N && RESET_N) [*4] |-> DATA_OE;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("bus not driven on read");

	property p_rx_flag;
		RXS_VALID && RXS_READY |-> ##[1:4] !RX_AVAIL_N_O;
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag stays high");

	property p_flush;
		$fell(SEND_NOW_WAKE_N) && !USB_SUSPEND |-> ##[2:6] TXS_FLUSH;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush pulse");

	property p_wake_sn;
		$fell(SEND_NOW_WAKE_N) && USB_SUSPEND |-> ##[2:6] RESUME_REQ;
	endproperty
	a_wake_sn: assert property (p_wake_sn) else $error("no resume on send strobe");

	property p_wake_early;
		RESUME_REQ && SEND_NOW_WAKE_N && $past(SEND_NOW_WAKE_N, 6) |-> $past(low_q, 3) >= WAKE_CYC;
	endproperty
	a_wake_early: assert property (p_wake_early) else $error("resume too early");

	property p_wake_late;
		low_q == WAKE_CYC + 8 |-> seen_q;
	endproperty
	a_wake_late: assert property (p_wake_late) else $error("resume missing");
endmodule

bind usb_parallel_fifo_port usb_parallel_fifo_port_checker #(.WAKE_CYC(WAKE_CYC)) chk (
	.REF_CLK, .SRST, .RESET_N, .RD_N, .DATA_OE, .TX_SPACE_N_OE, .RX_AVAIL_N_I,
	.RX_AVAIL_N_O, .RX_AVAIL_N_OE, .SEND_NOW_WAKE_N, .USB_SUSPEND, .RXS_VALID,
	.RXS_READY, .TXS_FLUSH, .RESUME_REQ
);

//--- verification/fifo_ctrl_model.sv
// Behavioural external controller on the FIFO strobes and pins.
`timescale 1ns/1ns
module fifo_ctrl_model (
	input  wire logic       REF_CLK,
	input  wire logic [7:0] DATA_O,
	input  wire logic       DATA_OE,
	input  wire logic       TX_SPACE_N_O,
	input  wire logic       RX_AVAIL_N_O,
	input  wire logic       RX_AVAIL_N_OE,
	output logic            RD_N,
	output logic            WR,
	output logic      [7:0] DATA_I,
	output logic            RX_AVAIL_N_I
);
	logic       drv     = 1'b0;  // Controller owns the bus
	logic [7:0] wd      = 8'h00; // Byte being written
	logic       wake_lo = 1'b0;  // Wake strobe held low
	logic [7:0] idle_q  = 8'h5A; // Floating bus pattern

	initial begin
		RD_N = 1'b1;
		WR = 1'b0;
	end

	// Undriven bus changes each cycle so no stale byte looks valid
	always @(posedge REF_CLK) idle_q <= ~idle_q;
	assign DATA_I = DATA_OE ? DATA_O : (drv ? wd : idle_q);
	// Controller drives the released pin high except while waking
	assign RX_AVAIL_N_I = RX_AVAIL_N_OE ? RX_AVAIL_N_O : !wake_lo;

	// Read only while data waits; low phase 5 clocks, high phase 4 clocks
	task automatic rd(output logic [7:0] b, output logic oe);
		@(negedge REF_CLK);
		b = 8'h00;
		oe = 1'b0;
		if (RX_AVAIL_N_O === 1'b0) begin
			RD_N = 1'b0;
			repeat (5) @(negedge REF_CLK);
			b = DATA_O;
			oe = DATA_OE;
			RD_N = 1'b1;
			repeat (4) @(negedge REF_CLK);
		end
	endtask

	// Write only with room; data held around the falling strobe
	task automatic wr(input logic [7:0] b);
		@(negedge REF_CLK);
		if (TX_SPACE_N_O === 1'b0) begin
			drv = 1'b1;
			wd = b;
			WR = 1'b1;
			repeat (4) @(negedge REF_CLK);
			WR = 1'b0;
			repeat (4) @(negedge REF_CLK);
			drv = 1'b0;
		end
	endtask

	// Holds the released receive pin low for n cycles
	task automatic wake(input int n);
		@(negedge REF_CLK);
		wake_lo = 1'b1;
		repeat (n) @(negedge REF_CLK);
		wake_lo = 1'b0;
	endtask
endmodule

//--- verification/usb_parallel_fifo_port_tb.sv
// Self-checking bench for the parallel FIFO port.
`timescale 1ns/1ns
module usb_parallel_fifo_port_tb
	import fifo_port_pkg::*;
;
	localparam int unsigned TX_DEPTH = 4;  // Short FIFOs
	localparam int unsigned WAKE_CYC = 20; // Shortened 20 ms hold

	logic       REF_CLK = 1'b0;
	logic       SRST = 1'b1;
	logic       RESET_N = 1'b1;
	logic       SEND_NOW_WAKE_N = 1'b1;
	logic       USB_SUSPEND = 1'b0;
	logic       RXS_VALID = 1'b0;
	logic [7:0] RXS_DATA = 8'h00;
	logic       TXS_READY = 1'b0;
	cfg_t       CFG = '0;
	logic       RD_N, WR, RX_AVAIL_N_I, DATA_OE, TX_SPACE_N_O, TX_SPACE_N_OE;
	logic       RX_AVAIL_N_O, RX_AVAIL_N_OE, POWER_ENABLE_N, PULL_UP_EN, PULL_DOWN_EN;
	logic       CONFIG_IO_5_O, CONFIG_IO_5_OE, CONFIG_IO_6_O, CONFIG_IO_6_OE;
	logic       RXS_READY, TXS_VALID, TXS_FLUSH, RESUME_REQ;
	logic [7:0] DATA_I, DATA_O, TXS_DATA;
	int         n_mismatch = 0;
	int         n_compared = 0;
	int         n_flush = 0;  // Flush pulses seen
	int         n_resume = 0; // Resume pulses seen
	int         cyc = 0;

	usb_parallel_fifo_port #(.RX_DEPTH(4), .TX_DEPTH(TX_DEPTH), .WAKE_CYC(WAKE_CYC)) dut (
		.REF_CLK, .SRST, .RESET_N, .RD_N, .WR, .DATA_I, .DATA_O, .DATA_OE, .TX_SPACE_N_O,
		.TX_SPACE_N_OE, .RX_AVAIL_N_I, .RX_AVAIL_N_O, .RX_AVAIL_N_OE, .SEND_NOW_WAKE_N,
		.POWER_ENABLE_N, .CONFIG_IO_5_O, .CONFIG_IO_5_OE, .CONFIG_IO_6_O, .CONFIG_IO_6_OE,
		.PULL_UP_EN, .PULL_DOWN_EN, .CFG, .USB_SUSPEND, .RXS_VALID, .RXS_DATA, .RXS_READY,
		.TXS_VALID, .TXS_DATA, .TXS_READY, .TXS_FLUSH, .RESUME_REQ
	);

	fifo_ctrl_model ctrl (
		.REF_CLK, .DATA_O, .DATA_OE, .TX_SPACE_N_O, .RX_AVAIL_N_O, .RX_AVAIL_N_OE,
		.RD_N, .WR, .DATA_I, .RX_AVAIL_N_I
	);

	initial forever #20 REF_CLK = ~REF_CLK;

	// Pulse counters and hang guard
	always @(negedge REF_CLK) begin
		cyc++;
		if (TXS_FLUSH === 1'b1) n_flush++;
		if (RESUME_REQ === 1'b1) n_resume++;
		if (cyc == 2000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	// Holds valid until the byte is taken; caller drops it
	task automatic push(input logic [7:0] b);
		@(negedge REF_CLK);
		RXS_VALID = 1'b1;
		RXS_DATA = b;
		// Ready is read between edges, where it stands still
		while (RXS_READY !== 1'b1) @(negedge REF_CLK);
		@(posedge REF_CLK);
	endtask

	task automatic t_reset();
		chk1(TX_SPACE_N_OE, 1'b1);
		chk1(TX_SPACE_N_O, 1'b0);
		chk1(RX_AVAIL_N_O, 1'b1);
		RESET_N = 1'b0;
		repeat (6) @(negedge REF_CLK);
		chk1(TX_SPACE_N_OE, 1'b0);
		chk1(RX_AVAIL_N_OE, 1'b0);
		RESET_N = 1'b1;
		repeat (6) @(negedge REF_CLK);
		chk1(RX_AVAIL_N_OE, 1'b1);
		$display("t_reset done");
	endtask

	// Four bytes in back to back fill the FIFO, then four reads in a row
	task automatic t_read();
		logic [7:0] b;
		logic       oe;
		for (logic [7:0] k = 8'h00; k < 8'h04; k++) push(8'h3C + 8'h5B * k);
		@(negedge REF_CLK);
		RXS_VALID = 1'b0;
		repeat (4) @(negedge REF_CLK);
		chk1(RX_AVAIL_N_O, 1'b0);
		chk1(RXS_READY, 1'b0);
		for (logic [7:0] k = 8'h00; k < 8'h04; k++) begin
			ctrl.rd(b, oe);
			chk1(oe, 1'b1);
			chk8(b, 8'h3C + 8'h5B * k);
		end
		chk1(RX_AVAIL_N_O, 1'b1);
		chk1(DATA_OE, 1'b0);
		$display("t_read done");
	endtask

	// Fill with the far side stalled, then drain while it stalls every other cycle
	task automatic t_write();
		int n;
		int k;
		n = 0;
		k = 0;
		while (TX_SPACE_N_O === 1'b0 && n < 40) begin
			ctrl.wr(8'h10 + 8'(n));
			n++;
		end
		chk1(n >= TX_DEPTH, 1'b1);
		repeat (80) begin
			@(negedge REF_CLK);
			TXS_READY = ~TXS_READY;
			// Handshake judged between edges, taken at the next rising edge
			if (TXS_VALID === 1'b1 && TXS_READY === 1'b1) begin
				chk8(TXS_DATA, 8'h10 + 8'(k));
				k++;
			end
		end
		chk1(k == n, 1'b1);
		chk1(TX_SPACE_N_O, 1'b0);
		@(negedge REF_CLK);
		$display("t_write done");
	endtask

	task automatic t_send(input logic susp);
		int f;
		int r;
		USB_SUSPEND = susp;
		repeat (3) @(negedge REF_CLK);
		f = n_flush;
		r = n_resume;
		SEND_NOW_WAKE_N = 1'b0;
		repeat (8) @(negedge REF_CLK);
		SEND_NOW_WAKE_N = 1'b1;
		repeat (4) @(negedge REF_CLK);
		chk8(8'(n_flush - f), {7'h00, !susp});
		chk8(8'(n_resume - r), {7'h00, susp});
		chk1(POWER_ENABLE_N, susp);
		$display("t_send done");
	endtask

	// Short low is ignored, long low wakes once
	task automatic t_wake();
		int r;
		CFG.remote_wake = 1'b1;
		CFG.suspend_pull_low = 1'b1;
		USB_SUSPEND = 1'b1;
		repeat (4) @(negedge REF_CLK);
		chk1(RX_AVAIL_N_OE, 1'b0);
		chk1(PULL_DOWN_EN, 1'b1);
		chk1(PULL_UP_EN, 1'b0);
		r = n_resume;
		ctrl.wake(int'(WAKE_CYC) - 4);
		repeat (10) @(negedge REF_CLK);
		chk8(8'(n_resume - r), 8'h00);
		ctrl.wake(int'(WAKE_CYC) + 10);
		repeat (10) @(negedge REF_CLK);
		chk8(8'(n_resume - r), 8'h01);
		CFG = '0;
		USB_SUSPEND = 1'b0;
		repeat (4) @(negedge REF_CLK);
		chk1(RX_AVAIL_N_OE, 1'b1);
		chk1(PULL_UP_EN, 1'b1);
		$display("t_wake done");
	endtask

	function automatic logic io_exp(input logic [3:0] c);
		case (c)
			4'h1: io_exp = TX_SPACE_N_O;
			4'h2: io_exp = RX_AVAIL_N_O;
			4'h3: io_exp = USB_SUSPEND;
			4'h5: io_exp = 1'b1;
			default: io_exp = 1'b0;
		endcase
	endfunction

	// Every function code on both pins, code 6 unassigned
	task automatic t_cfgio();
		logic [3:0] c;
		USB_SUSPEND = 1'b1; // Suspend code then differs from constant low
		for (int i = 0; i < 7; i++) begin
			c = 4'(i);
			CFG.io5_sel = c;
			CFG.io6_sel = 4'h6 - c;
			repeat (3) @(negedge REF_CLK);
			chk1(CONFIG_IO_5_OE, c inside {[4'h1:4'h5]});
			chk1(CONFIG_IO_6_OE, (4'h6 - c) inside {[4'h1:4'h5]});
			if (c inside {[4'h1:4'h5]}) chk1(CONFIG_IO_5_O, io_exp(c));
			if (c != 4'h0) chk1(CONFIG_IO_6_O, io_exp(4'h6 - c));
		end
		USB_SUSPEND = 1'b0;
		$display("t_cfgio done");
	endtask

	initial begin
		repeat (4) @(negedge REF_CLK);
		SRST = 1'b0;
		repeat (4) @(negedge REF_CLK);
		t_reset();
		t_read();
		t_write();
		t_send(1'b0);
		t_send(1'b1);
		t_wake();
		t_cfgio();
		print_verdict();
	end
endmodule
